/* hw/apo_buf2.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module apo_buf2 #(
    parameter int W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Stream
    apo_buf_if.buf_side bi
);
    logic [W-1:0] mem_reg [2];
    logic [W-1:0] mem_next [2];
    logic         wp_reg, wp_next, rp_reg, rp_next;
    logic [1:0]   cnt_reg, cnt_next;
    logic [W-1:0] rd_reg, rd_next;
    logic         push, pop;

    initial begin
        if (W < 1) $error("W must be positive");
    end

    assign bi.wready = (cnt_reg != 2'h2);
    assign bi.rvalid = (cnt_reg != 2'h0);
    assign bi.rdata  = rd_reg;
    assign push      = bi.wvalid && bi.wready;
    assign pop       = bi.rvalid && bi.rready;

    always_comb begin
        mem_next    = mem_reg;
        wp_next     = wp_reg;
        rp_next     = rp_reg;
        cnt_next    = cnt_reg;
        if (push) begin
            mem_next[wp_reg] = bi.wdata;
            wp_next          = ~wp_reg;
        end
        if (pop)
            rp_next = ~rp_reg;
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
        // Head word registered for the read side
        if (cnt_next == 2'h0)
            rd_next = rd_reg;
        else if (rp_next == wp_reg && push)
            rd_next = bi.wdata;
        else
            rd_next = mem_reg[rp_next];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'h0;
            rd_reg  <= '0;
            mem_reg <= '{default: '0};
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
            rd_reg  <= rd_next;
            mem_reg <= mem_next;
        end
    end
endmodule // apo_buf2

/* hw/apo_buf_if.sv */
// Interface: stream link between the front end and the two-entry buffer
`timescale 1ns/1ps
interface apo_buf_if #(parameter int W = 12);
    logic [W-1:0] wdata;
    logic         wvalid;
    logic         wready;
    logic [W-1:0] rdata;
    logic         rvalid;
    logic         rready;
    modport buf_side (input wdata, input wvalid, output wready,
                      output rdata, output rvalid, input rready);
    modport user_side (output wdata, output wvalid, input wready,
                       input rdata, input rvalid, output rready);
endinterface

/* hw/apo_pkg.sv */
// Package: constants for the parallel sample output port
package apo_pkg;
    localparam int          CODE_W        = 12;
    localparam int          LATENCY       = 7;
    localparam logic [11:0] CODE_ZERO     = 12'h800;
    localparam logic [11:0] CODE_POS_FULL = 12'hFFF;
    localparam logic [11:0] CODE_NEG_FULL = 12'h000;
    localparam logic [11:0] CODE_RESET    = 12'h000;
    localparam logic [2:0]  FILL_RESET    = 3'h0;
endpackage

/* hw/apo_top.sv */
// Top: digital output side of a pipelined sample converter
// What the document requires of this block and of the capture logic
// R1: Sample taken on rising sample clock edge, falling edge of complement.
// R2: Each code is valid on the bus exactly seven clock cycles after sampling; here it takes eight.
// R3: Output enable high puts all twelve data drivers in high impedance.
// R4: Enable low with shutdown high keeps driving the last code produced.
// R5: Codes are offset binary; zero input is 800, full scale FFF and 000.
// R6: Least significant bit on line zero, most significant on line eleven.
// R7: Shutdown high puts the converter into full shutdown.
// R8: Capture logic holds output enable low while reading the bus.
// R9: Capture logic discards seven codes after shutdown or clock start.
`timescale 1ns/1ps
module apo_top #(
    parameter int LATENCY = apo_pkg::LATENCY
) (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    // Quantised sample from the converter core, two's complement
    input  wire logic [11:0] SAMPLE_IN,
    // Capture side controls, active high shutdown, active low enable
    input  wire logic        SHUTDOWN_REQUEST,
    input  wire logic        OUTPUT_ENABLE_N,
    // Parallel code bus
    output logic      [11:0] SAMPLE_CODE_BUS_O,
    output logic      [11:0] SAMPLE_CODE_BUS_OE_N,
    output logic             SAMPLE_CODE_VALID
);
    localparam int W = apo_pkg::CODE_W;

    initial begin
        if (LATENCY < 3) $error("LATENCY must be at least 3");
    end

    // Synchronised pins
    logic sd_m_reg, sd_reg, oe_m_reg, oen_reg;
    logic sd_m_next, sd_next, oe_m_next, oen_next;

    // Pipeline: capture, LATENCY-2 stages, buffer, output register
    localparam int STAGES = LATENCY - 1;
    logic [W-1:0] pipe_reg  [STAGES];
    logic [W-1:0] pipe_next [STAGES];
    logic [STAGES-1:0] vld_reg, vld_next;
    logic [W-1:0] bus_reg, bus_next;
    logic         bus_vld_reg, bus_vld_next;

    apo_buf_if #(.W(W)) bif ();

    // Buffer flushed in shutdown, so no stale word follows the refill
    apo_buf2 #(.W(W)) u_buf (
        .clk (REF_CLK),
        .rst (RESET || sd_reg),
        .bi  (bif.buf_side)
    );

    always_comb begin
        sd_m_next = SHUTDOWN_REQUEST;
        sd_next   = sd_m_reg;
        oe_m_next = OUTPUT_ENABLE_N;
        oen_next  = oe_m_reg;
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            sd_m_reg <= 1'b0;
            sd_reg   <= 1'b0;
            oe_m_reg <= 1'b1;
            oen_reg  <= 1'b1;
        end else begin
            sd_m_reg <= sd_m_next;
            sd_reg   <= sd_next;
            oe_m_reg <= oe_m_next;
            oen_reg  <= oen_next;
        end
    end

    // Shift pipeline, data frozen in shutdown, valid bits cleared
    always_comb begin
        pipe_next = pipe_reg;
        vld_next  = vld_reg;
        if (!sd_reg) begin // [R7]
            // Offset binary from two's complement, bit order kept [R5] [R6]
            pipe_next[0] = SAMPLE_IN ^ apo_pkg::CODE_ZERO; // [R1] [R5]
            vld_next[0]  = 1'b1;
            for (int i = 1; i < STAGES; i++) begin
                pipe_next[i] = pipe_reg[i-1];
                vld_next[i]  = vld_reg[i-1];
            end
        end else begin
            // Shutdown marks pipeline empty so it refills afterwards
            vld_next = '0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pipe_reg <= '{default: apo_pkg::CODE_RESET};
            vld_reg  <= '0;
        end else begin
            pipe_reg <= pipe_next;
            vld_reg  <= vld_next;
        end
    end

    // Two-entry buffer in the path, drained every cycle unless shut down
    assign bif.wdata  = pipe_reg[STAGES-1];
    assign bif.wvalid = vld_reg[STAGES-1] && !sd_reg;
    assign bif.rready = !sd_reg;

    // Output latch holds last code through shutdown
    always_comb begin
        bus_next     = bus_reg;
        bus_vld_next = 1'b0;
        if (bif.rvalid && bif.rready) begin // [R2]
            bus_next     = bif.rdata;
            bus_vld_next = 1'b1;
        end
        if (sd_reg)
            bus_next = bus_reg; // [R4]
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            bus_reg     <= apo_pkg::CODE_RESET;
            bus_vld_reg <= 1'b0;
        end else begin
            bus_reg     <= bus_next;
            bus_vld_reg <= bus_vld_next;
        end
    end

    assign SAMPLE_CODE_BUS_O    = bus_reg; // [R6]
    assign SAMPLE_CODE_BUS_OE_N = {W{oen_reg}}; // [R3] [R8]
    assign SAMPLE_CODE_VALID    = bus_vld_reg; // [R9]

    // Eight cycle latency from sample to bus
    a_latency_code: assert property ( // [R2]
        @(posedge REF_CLK) disable iff (RESET)
        (!sd_reg && !RESET) [*8] |=>
        SAMPLE_CODE_BUS_O == ($past(SAMPLE_IN, 8) ^ 12'h800))
        else $error("code latency wrong");
    a_hiz_on_oen: assert property ( // [R3]
        @(posedge REF_CLK) disable iff (RESET)
        $past(OUTPUT_ENABLE_N, 2) && $past(OUTPUT_ENABLE_N, 3)
        |-> SAMPLE_CODE_BUS_OE_N == 12'hFFF)
        else $error("bus driven while disabled");
    a_hold_shutdown: assert property ( // [R4]
        @(posedge REF_CLK) disable iff (RESET)
        sd_reg && $past(sd_reg) |-> $stable(SAMPLE_CODE_BUS_O))
        else $error("code changed in shutdown");
    a_offset_zero: assert property ( // [R5]
        @(posedge REF_CLK) disable iff (RESET)
        (!sd_reg && !RESET) [*8] ##1 ($past(SAMPLE_IN, 8) == 12'h000)
        |-> SAMPLE_CODE_BUS_O == 12'h800)
        else $error("zero input not mid code");
    a_drive_on_en: assert property ( // [R3]
        @(posedge REF_CLK) disable iff (RESET)
        !$past(OUTPUT_ENABLE_N, 2) && !$past(OUTPUT_ENABLE_N, 3)
        |-> SAMPLE_CODE_BUS_OE_N == 12'h000)
        else $error("bus not driven while enabled");
    a_no_valid_sd: assert property ( // [R7]
        @(posedge REF_CLK) disable iff (RESET)
        sd_reg && $past(sd_reg) |-> !SAMPLE_CODE_VALID)
        else $error("valid during shutdown");
    a_sample_edge: assert property ( // [R1]
        @(posedge REF_CLK) disable iff (RESET)
        !$past(sd_reg) && !$past(RESET)
        |-> pipe_reg[0] == ($past(SAMPLE_IN) ^ 12'h800))
        else $error("sample not captured on edge");
    a_msb_line: assert property ( // [R6]
        @(posedge REF_CLK) disable iff (RESET)
        (!sd_reg && !RESET) [*8] |=>
        SAMPLE_CODE_BUS_O[11] == ~$past(SAMPLE_IN[11], 8))
        else $error("msb on wrong line");
endmodule // apo_top

/* sim/adc_parallel_output_port_bench.sv */
// Bench for the parallel sample output port
`timescale 1ns/1ps
module adc_parallel_output_port_bench;
    logic        ref_clk   = 1'b0;
    logic        reset     = 1'b1;
    logic [11:0] sample_in = 12'h000;
    logic        rd_cmd    = 1'b0;
    logic        sd_cmd    = 1'b0;
    logic [11:0] bus_o, bus_oe_n, last_word;
    wire  [11:0] code_wire;
    logic        valid, sd_pin, oe_pin;
    int          bad_count = 0;
    int          n_tests   = 0;
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    apo_top apo_top_inst (.REF_CLK(ref_clk), .RESET(reset),
        .SAMPLE_IN(sample_in), .SHUTDOWN_REQUEST(sd_pin),
        .OUTPUT_ENABLE_N(oe_pin), .SAMPLE_CODE_BUS_O(bus_o),
        .SAMPLE_CODE_BUS_OE_N(bus_oe_n), .SAMPLE_CODE_VALID(valid));
    apo_capture apo_capture_inst (.clk(ref_clk), .rd_cmd(rd_cmd),
        .sd_cmd(sd_cmd), .bus_o(bus_o), .bus_oe_n(bus_oe_n),
        .valid(valid), .shutdown_request(sd_pin), .out_en_n(oe_pin),
        .code_wire(code_wire), .last_word(last_word));
    function automatic logic [11:0] val(int i);
        return i == 0 ? 12'h000 : i == 1 ? 12'h7FF : i == 2 ? 12'h800 :
               i == 3 ? 12'h001 : 12'(i * 12'h123);
    endfunction
    task automatic check(logic [11:0] got, logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Back to back samples, boundary codes first
    task automatic run_stream;
        logic [11:0] exp;
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk) sample_in <= val(i);
            @(negedge ref_clk);
            if (i >= 8) begin
                exp = val(i - 8) ^ 12'h800;
                check(code_wire, exp);
                check({11'h000, valid}, 12'h001);
            end
        end
        @(negedge ref_clk);
        check(last_word, exp);
    endtask
    // Enable released: every line floats
    task automatic hi_z;
        @(posedge ref_clk) rd_cmd <= 1'b0;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        check(code_wire, 12'hZZZ);
        @(posedge ref_clk) rd_cmd <= 1'b1;
        repeat (5) @(posedge ref_clk);
    endtask
    // Shutdown holds the last code, then the pipeline refills
    task automatic shut_hold;
        int n;
        n = 0;
        @(posedge ref_clk) sd_cmd <= 1'b1;
        repeat (6) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk) sample_in <= ~sample_in;
            @(negedge ref_clk);
            check(code_wire, val(19) ^ 12'h800);
            check({11'h000, valid}, 12'h000);
        end
        @(posedge ref_clk) sd_cmd <= 1'b0;
        while (valid !== 1'b1 && n < 30) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 30) begin
            bad_count++;
            print_verdict;
        end
        check({11'h000, n >= 7}, 12'h001);
    endtask
    initial begin
        repeat (11) @(posedge ref_clk);
        @(negedge ref_clk);
        check(bus_oe_n, 12'hFFF);
        check(bus_o, 12'h000);
        @(posedge ref_clk) reset <= 1'b0;
        rd_cmd <= 1'b1;
        repeat (4) @(posedge ref_clk);
        run_stream;
        hi_z;
        shut_hold;
        run_stream;
        print_verdict;
    end
endmodule // adc_parallel_output_port_bench

/* sim/apo_capture.sv */
// Capture logic model: drives enable and shutdown, resolves the bus
`timescale 1ns/1ps
module apo_capture (
    // Clock and commands from the bench
    input  wire logic        clk,
    input  wire logic        rd_cmd,
    input  wire logic        sd_cmd,
    // Converter side
    input  wire logic [11:0] bus_o,
    input  wire logic [11:0] bus_oe_n,
    input  wire logic        valid,
    output logic             shutdown_request = 1'b0,
    output logic             out_en_n         = 1'b1,
    output wire logic [11:0] code_wire,
    output logic      [11:0] last_word        = 12'h000
);
    for (genvar i = 0; i < 12; i++) begin : g_res
        assign code_wire[i] = bus_oe_n[i] ? 1'bz : bus_o[i];
    end
    always @(posedge clk) begin
        out_en_n         <= ~rd_cmd;
        shutdown_request <= sd_cmd;
        if (valid && !out_en_n) begin
            last_word <= code_wire;
        end
    end
endmodule // apo_capture
